// ==== common/ccthr_pkg.sv ====
// package: offsets, field layouts, reset values and the fast-charge current code table of the charger threshold registers
package ccthr_pkg;
	localparam int   ADDR_W                = 8;
	localparam int   DATA_W                = 8;
	localparam logic [7:0] CHG_CUR_OFFSET  = 8'h04;
	localparam logic [7:0] VTHR_OFFSET     = 8'h05;
	localparam logic [7:0] UNMAPPED_READ   = 8'h00;
	// charge current settings layout
	localparam int   FCC_MSB               = 6;
	localparam int   FCC_LSB               = 2;
	localparam int   TWC_MSB               = 1;
	localparam int   TWC_LSB               = 0;
	localparam int   CHG_UNUSED_BIT        = 7;
	// voltage threshold settings layout
	localparam int   RCH_DIS_BIT           = 7;
	localparam int   RCH_MSB               = 6;
	localparam int   RCH_LSB               = 5;
	localparam int   DBT_MSB               = 4;
	localparam int   DBT_LSB               = 3;
	localparam int   WBT_MSB               = 2;
	localparam int   WBT_LSB               = 0;
	// reset values
	localparam logic [4:0] FCC_RESET       = 5'h0E;
	localparam logic [1:0] TWC_RESET       = 2'h2;
	localparam logic       RCH_DIS_RESET   = 1'b0;
	localparam logic [1:0] RCH_RESET       = 2'h3;
	localparam logic [1:0] DBT_RESET       = 2'h0;
	localparam logic [2:0] WBT_RESET       = 3'h3;
	// fast-charge current table: linear region, then two fixed top steps
	localparam logic [4:0] FCC_LINEAR_MAX  = 5'h15;
	localparam logic [4:0] FCC_STEP_1200   = 5'h16;
	localparam int   FCC_BASE_MA           = 50;
	localparam int   FCC_STEP_MA           = 50;
	localparam logic [10:0] FCC_1200_MA    = 11'h4B0;
	localparam logic [10:0] FCC_MAX_MA     = 11'h514;
endpackage : ccthr_pkg

// ==== core/ccthr_fcc_decode.sv ====
// fast-charge current code to milliamp decoder for the charger core
`timescale 1ns/1ns
module ccthr_fcc_decode (
	// code in
	input  wire logic [4:0]  code_i,
	// current out
	output logic      [10:0] current_ma_o
);
	import ccthr_pkg::*;

	always_comb begin
		if (code_i <= FCC_LINEAR_MAX) begin
			current_ma_o = 11'(FCC_BASE_MA + FCC_STEP_MA * int'(code_i));
		end else if (code_i == FCC_STEP_1200) begin
			current_ma_o = FCC_1200_MA;
		end else begin
			current_ma_o = FCC_MAX_MA;
		end
	end
endmodule : ccthr_fcc_decode

// ==== core/ccthr_regs.sv ====
// charge current and voltage threshold configuration registers
`timescale 1ns/1ns
// Overview of operation
// - bits 6:2 of the charge current register hold the fast-charge code, 50 mA steps to 10101.
// - code 10110 means 1200 mA and any code from 10111 up means the 1300 mA maximum.
// - bits 1:0 hold the trickle/weak current code (5, 10, 20, 80 mA) resetting to 10.
// - bit 7 of the voltage threshold register disables recharge when set and resets to 0.
// - bits 6:5 hold the recharge offset code (80 to 260 mV) resetting to 11.
// - bits 4:3 hold the dead-battery threshold code (2.0 to 2.9 V) resetting to 00.
// - bits 2:0 hold the weak-battery rising threshold code (2.7 to 3.4 V), resetting to 011.
module ccthr_regs (
	// clock and reset
	input  wire logic                          clk_i,
	input  wire logic                          resetn_i,
	// register port from the serial interface engine
	input  wire logic                          wr_en_i,
	input  wire logic                          rd_en_i,
	input  wire logic [ccthr_pkg::ADDR_W-1:0]  addr_i,
	input  wire logic [ccthr_pkg::DATA_W-1:0]  wdata_i,
	output logic      [ccthr_pkg::DATA_W-1:0]  rdata_o,
	// static codes and the decoded fast-charge current to the charger core
	output logic      [4:0]                    fast_charge_current_code_o,
	output logic      [1:0]                    trickle_weak_current_code_o,
	output logic                               recharge_disable_o,
	output logic      [1:0]                    recharge_offset_code_o,
	output logic      [1:0]                    dead_battery_threshold_code_o,
	output logic      [2:0]                    weak_battery_threshold_code_o,
	output logic      [10:0]                   fast_charge_current_ma_o
);
	import ccthr_pkg::*;

	// field widths follow the register layout
	localparam int FCC_W = FCC_MSB - FCC_LSB + 1;
	localparam int TWC_W = TWC_MSB - TWC_LSB + 1;
	localparam int RCH_W = RCH_MSB - RCH_LSB + 1;
	localparam int DBT_W = DBT_MSB - DBT_LSB + 1;
	localparam int WBT_W = WBT_MSB - WBT_LSB + 1;

	// stored fields
	logic [FCC_W-1:0]  fast_charge_current_code_r;
	logic [TWC_W-1:0]  trickle_weak_current_code_r;
	logic              recharge_disable_r;
	logic [RCH_W-1:0]  recharge_offset_code_r;
	logic [DBT_W-1:0]  dead_battery_threshold_code_r;
	logic [WBT_W-1:0]  weak_battery_threshold_code_r;

	// register images and read path
	logic [DATA_W-1:0] chg_word;
	logic [DATA_W-1:0] vthr_word;
	logic [DATA_W-1:0] rdata_r;
	logic [DATA_W-1:0] rdata_nxt;

	// decoded fast-charge current
	logic [10:0]       fcc_ma_nxt;
	logic [10:0]       fcc_ma_r;

	// address decode
	logic              sel_chg;
	logic              sel_vthr;
	logic              wr_chg;
	logic              wr_vthr;

	// only the two mapped offsets select anything; writes elsewhere are dropped
	always_comb begin
		sel_chg  = 1'b0;
		sel_vthr = 1'b0;
		if (addr_i == CHG_CUR_OFFSET) begin
			sel_chg = 1'b1;
		end else if (addr_i == VTHR_OFFSET) begin
			sel_vthr = 1'b1;
		end
	end

	assign wr_chg  = wr_en_i && sel_chg;
	assign wr_vthr = wr_en_i && sel_vthr;

	// fast-charge code; bit 7 of this register has no storage so writes to it vanish
	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			fast_charge_current_code_r <= FCC_RESET;
		end else if (wr_chg) begin
			fast_charge_current_code_r <= wdata_i[FCC_MSB:FCC_LSB];
		end
	end

	// trickle and weak current shares the write of the charge current register
	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			trickle_weak_current_code_r <= TWC_RESET;
		end else if (wr_chg) begin
			trickle_weak_current_code_r <= wdata_i[TWC_MSB:TWC_LSB];
		end
	end

	// a set bit stops new recharge cycles; the offset code is kept but unused then
	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			recharge_disable_r <= RCH_DIS_RESET;
		end else if (wr_vthr) begin
			recharge_disable_r <= wdata_i[RCH_DIS_BIT];
		end
	end

	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			recharge_offset_code_r <= RCH_RESET;
		end else if (wr_vthr) begin
			recharge_offset_code_r <= wdata_i[RCH_MSB:RCH_LSB];
		end
	end

	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			dead_battery_threshold_code_r <= DBT_RESET;
		end else if (wr_vthr) begin
			dead_battery_threshold_code_r <= wdata_i[DBT_MSB:DBT_LSB];
		end
	end

	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			weak_battery_threshold_code_r <= WBT_RESET;
		end else if (wr_vthr) begin
			weak_battery_threshold_code_r <= wdata_i[WBT_MSB:WBT_LSB];
		end
	end

	// register images as the host reads them
	always_comb begin
		chg_word                  = '0;
		chg_word[CHG_UNUSED_BIT]  = 1'b0;
		chg_word[FCC_MSB:FCC_LSB] = fast_charge_current_code_r;
		chg_word[TWC_MSB:TWC_LSB] = trickle_weak_current_code_r;
	end

	always_comb begin
		vthr_word                  = '0;
		vthr_word[RCH_DIS_BIT]     = recharge_disable_r;
		vthr_word[RCH_MSB:RCH_LSB] = recharge_offset_code_r;
		vthr_word[DBT_MSB:DBT_LSB] = dead_battery_threshold_code_r;
		vthr_word[WBT_MSB:WBT_LSB] = weak_battery_threshold_code_r;
	end

	// read mux; unmapped addresses return zero, and a read in the cycle of a write sees old data
	always_comb begin
		rdata_nxt = UNMAPPED_READ;
		if (sel_chg) begin
			rdata_nxt = chg_word;
		end else if (sel_vthr) begin
			rdata_nxt = vthr_word;
		end
	end

	// read data registered so the output comes from a flip-flop; holds between reads
	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			rdata_r <= UNMAPPED_READ;
		end else if (rd_en_i) begin
			rdata_r <= rdata_nxt;
		end
	end

	ccthr_fcc_decode u_fcc_decode (
		.code_i       (fast_charge_current_code_r),
		.current_ma_o (fcc_ma_nxt)
	);

	// decoded current lags the code by one cycle to keep the output registered
	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			fcc_ma_r <= FCC_BASE_MA[10:0] + 11'(FCC_STEP_MA * int'(FCC_RESET));
		end else begin
			fcc_ma_r <= fcc_ma_nxt;
		end
	end

	assign rdata_o                       = rdata_r;
	assign fast_charge_current_code_o    = fast_charge_current_code_r;
	assign trickle_weak_current_code_o   = trickle_weak_current_code_r;
	assign recharge_disable_o            = recharge_disable_r;
	assign recharge_offset_code_o        = recharge_offset_code_r;
	assign dead_battery_threshold_code_o = dead_battery_threshold_code_r;
	assign weak_battery_threshold_code_o = weak_battery_threshold_code_r;
	assign fast_charge_current_ma_o      = fcc_ma_r;
endmodule : ccthr_regs

// ==== sim/ccthr_chk.sv ====
// assertion checker for the charger threshold registers
`timescale 1ns/1ns
module ccthr_chk (
	input wire logic        clk_i, resetn_i, wr_en_i, rd_en_i,
	input wire logic [7:0]  addr_i, wdata_i, rdata_o,
	input wire logic [4:0]  fast_charge_current_code_o,
	input wire logic [1:0]  trickle_weak_current_code_o, recharge_offset_code_o,
	input wire logic        recharge_disable_o,
	input wire logic [1:0]  dead_battery_threshold_code_o,
	input wire logic [2:0]  weak_battery_threshold_code_o,
	input wire logic [10:0] fast_charge_current_ma_o
);
	// all stored fields packed in register order, bit 7 of the current register left out
	wire logic [14:0] cod = {fast_charge_current_code_o, trickle_weak_current_code_o,
		recharge_disable_o, recharge_offset_code_o, dead_battery_threshold_code_o,
		weak_battery_threshold_code_o};
	default clocking @(posedge clk_i); endclocking
	default disable iff (!resetn_i);
	wr_cur_a: assert property (wr_en_i && addr_i == 8'h04
		|=> cod[14:8] == $past(wdata_i[6:0]) && $stable(cod[7:0]))
		else $error("current write not stored");
	wr_thr_a: assert property (wr_en_i && addr_i == 8'h05
		|=> cod[7:0] == $past(wdata_i) && $stable(cod[14:8]))
		else $error("threshold write not stored");
	code_hold_a: assert property (!(wr_en_i && (addr_i == 8'h04 || addr_i == 8'h05))
		|=> $stable(cod)) else $error("codes moved without a write");
	rd_cur_a: assert property (rd_en_i && addr_i == 8'h04
		|=> rdata_o == {1'b0, $past(cod[14:8])}) else $error("current read wrong");
	rd_thr_a: assert property (rd_en_i && addr_i == 8'h05
		|=> rdata_o == $past(cod[7:0])) else $error("threshold read wrong");
	rd_hold_a: assert property (!rd_en_i |=> $stable(rdata_o))
		else $error("read data moved without a read");
	ma_lin_a: assert property (cod[14:10] <= 5'h15 |=> fast_charge_current_ma_o
		== 11'h32 + 11'h32 * $past(cod[14:10])) else $error("linear current wrong");
	ma_mid_a: assert property (cod[14:10] == 5'h16
		|=> fast_charge_current_ma_o == 11'h4B0) else $error("1200 mA step wrong");
	ma_max_a: assert property (cod[14:10] > 5'h16
		|=> fast_charge_current_ma_o == 11'h514) else $error("top current wrong");
	rd_unm_a: assert property (rd_en_i && addr_i != 8'h04 && addr_i != 8'h05
		|=> rdata_o == 8'h00) else $error("unmapped read not zero");
	rst_val_a: assert property ($rose(resetn_i) |-> cod == 15'h3A63
		&& fast_charge_current_ma_o == 11'h2EE && rdata_o == 8'h00)
		else $error("reset values wrong");
endmodule : ccthr_chk
bind ccthr_regs ccthr_chk ccthr_chk_i (.clk_i, .resetn_i, .wr_en_i, .rd_en_i, .addr_i, .wdata_i,
	.rdata_o, .fast_charge_current_code_o, .trickle_weak_current_code_o, .recharge_offset_code_o,
	.recharge_disable_o, .dead_battery_threshold_code_o, .weak_battery_threshold_code_o,
	.fast_charge_current_ma_o);

// ==== sim/ccthr_host.sv ====
// host-side model issuing single register writes and reads
`timescale 1ns/1ns
module ccthr_host (
	input  wire logic       clk_i,
	input  wire logic [7:0] rdata_i,
	output logic            wr_en_o, rd_en_o,
	output logic [7:0]      addr_o, wdata_o
);
	initial {wr_en_o, rd_en_o, addr_o, wdata_o} = 18'h0;
	// idle bus shows inverted values so a stale address can never pass for a live one
	task automatic xfer(input logic w, input logic [7:0] a, d, output logic [7:0] q);
		@(posedge clk_i) #1;
		{wr_en_o, rd_en_o, addr_o, wdata_o} = {w, !w, a, d};
		@(posedge clk_i) #1;
		{wr_en_o, rd_en_o, addr_o, wdata_o} = {2'h0, ~a, ~d};
		q = rdata_i;
	endtask : xfer
endmodule : ccthr_host

// ==== sim/tb.sv ====
// self-checking bench for the charger threshold registers
`timescale 1ns/1ns
module tb;
	logic clk = 1'b0, rstn = 1'b0, we, re, dis;
	logic [7:0] a, wd, rd, q, ad, dv;
	logic [4:0] fcc;
	logic [1:0] trk, off, dead;
	logic [2:0] wk;
	logic [10:0] ma;
	int mismatches = 0, check_count = 0, seed = 91, m4 = 8'h3A, m5 = 8'h63;
	always #20 clk = ~clk;
	ccthr_host ccthr_host_i (.clk_i(clk), .rdata_i(rd), .wr_en_o(we), .rd_en_o(re), .addr_o(a),
		.wdata_o(wd));
	ccthr_regs ccthr_regs_i (.clk_i(clk), .resetn_i(rstn), .wr_en_i(we), .rd_en_i(re), .addr_i(a),
		.wdata_i(wd), .rdata_o(rd), .fast_charge_current_code_o(fcc),
		.trickle_weak_current_code_o(trk), .recharge_disable_o(dis), .recharge_offset_code_o(off),
		.dead_battery_threshold_code_o(dead), .weak_battery_threshold_code_o(wk),
		.fast_charge_current_ma_o(ma));
	task automatic chk(input string n, input logic [15:0] s, input int e);
		check_count++;
		if (s !== 16'(e)) begin
			mismatches++;
			$display("CHECK FAILED %s expected %0h seen %0h", n, e, s);
		end
	endtask : chk
	function automatic int dec(input int c);
		return c < 22 ? 50 + 50 * c : (c == 22 ? 1200 : 1300);
	endfunction : dec
	task automatic look();
		chk("codes", {1'b0, fcc, trk, dis, off, dead, wk}, {m4[6:0], m5[7:0]});
		chk("ma", {5'h00, ma}, dec(m4[6:2]));
	endtask : look
	task automatic end_of_test();
		$display("checks %0d mismatches %0d", check_count, mismatches);
		if (mismatches == 0 && check_count > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask : end_of_test
	initial begin
		repeat (20) @(posedge clk);
		#1 rstn = 1'b1;
		look();
		// every fast-charge code in turn, then random traffic over mapped and unmapped places
		for (int i = 0; i < 48; i++) begin
			ad = i < 32 ? 8'h04 : 8'($random(seed)) & 8'h07;
			dv = 8'($random(seed));
			if (i < 32) dv[6:2] = i[4:0];
			ccthr_host_i.xfer(1'b1, ad, dv, q);
			if (ad == 8'h04) m4 = dv & 8'h7F;
			if (ad == 8'h05) m5 = dv;
			ccthr_host_i.xfer(1'b0, ad, 8'h00, q);
			chk("rdata", q, ad == 8'h04 ? m4 : (ad == 8'h05 ? m5 : 0));
			look();
		end
		// reset again in mid-run: every field and the read data fall back to reset values
		rstn = 1'b0;
		repeat (3) @(posedge clk);
		#1 rstn = 1'b1;
		m4 = 8'h3A;
		m5 = 8'h63;
		look();
		ccthr_host_i.xfer(1'b0, 8'h05, 8'h00, q);
		chk("rdata", q, m5);
		ccthr_host_i.xfer(1'b0, 8'h04, 8'h00, q);
		chk("rdata", q, m4);
		end_of_test();
	end
	initial begin
		#100000;
		mismatches++;
		end_of_test();
	end
endmodule : tb
